// ==== hw/ueh_endpoint_handshake_control.sv ====
// endpoint handshake control: stall, nak-event, disable and toggle registers
//
// What this block does
// - ACK status stage while acknowledge bit set
// - NAK status stage until acknowledged or stalled
// - acknowledge bit clears on ACK, setup, stall
// - stall-status bit stalls status stage, setup clears
// - EP2/EP3 IN stall bits force STALL
// - EP1 OUT stall bit forces STALL
// - EP0 OUT stall, cleared by setup token
// - EP0 IN stall, cleared by setup token
// - NAK on IN sets sticky event flag
// - reserved bits read back as zero
// - disable bits block endpoint traffic
// - endpoint 0 can never be disabled
// - toggle-clear write forces DATA0 unless a transfer on that endpoint completes in the clearing cycle, self-clears
// - bus reset zeroes toggle-clear bits
// - endpoint 0 toggle handled internally only
// - bus reset restores endpoint register defaults; interrupt status and mask are kept
`timescale 1ns/100ps
`default_nettype none
module ueh_endpoint_handshake_control
    import ueh_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tokValid,
    input wire ueh_tok_t tokKind,
    input wire logic [1:0] tokEp,
    input wire logic tokStatus,
    input wire logic bufReady,
    input wire logic xferOk,
    input wire logic [1:0] xferEp,
    input wire logic busReset,
    output logic hsValid,
    output ueh_hs_t hsCode,
    output logic [3:0] dataToggle,
    output logic irq
);

    // ---------------------------------------------------------------
    // state record
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] stallCtl;
        logic [7:0] nakSeen;
        logic [7:0] disTgl;
        logic [3:0] toggle;
        logic [INT_W-1:0] intStatus;
        logic [INT_W-1:0] intMask;
        logic [31:0] rdData;
        logic hsValid;
        ueh_hs_t hsCode;
    } ueh_state_t;

    localparam ueh_state_t ST_RESET = '{
        stallCtl: RST_STALL,
        nakSeen: RST_NAK,
        disTgl: RST_DIS,
        toggle: RST_TOGGLE,
        intStatus: RST_INT,
        intMask: RST_INT,
        rdData: 32'h0000_0000,
        hsValid: 1'b0,
        hsCode: HS_NONE
    };

    ueh_state_t state_r;
    ueh_state_t state_nxt;

    // ---------------------------------------------------------------
    // answer logic
    // ---------------------------------------------------------------
    ueh_tok_if tokBus ();

    // the answer logic sees the registered controls, so a CPU write
    // lands one cycle before it can steer a handshake
    assign tokBus.tokKind = tokKind;
    assign tokBus.tokEp = tokEp;
    assign tokBus.tokStatus = tokStatus;
    assign tokBus.bufReady = bufReady;
    assign tokBus.stallCtl = state_r.stallCtl;
    assign tokBus.disTgl = state_r.disTgl;

    ueh_handshake_decide decideInst (
        .tok (tokBus.decide)
    );

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic [5:0] regIdx;
    logic addrHit;
    logic accessWr;
    logic setupRd;
    logic [7:0] rdByte;

    // any address outside the five words answers with an error
    assign regIdx = paddr[7:2];
    assign addrHit = (paddr[1:0] == 2'b00) &&
        (regIdx == IDX_STALL || regIdx == IDX_NAK || regIdx == IDX_DIS_TGL ||
         regIdx == IDX_INT_STATUS || regIdx == IDX_INT_MASK);
    assign accessWr = psel && penable && pwrite && addrHit;
    assign setupRd = psel && !penable && !pwrite;

    // zero wait states; read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrHit;

    // read multiplexer, reserved bits masked off at the source
    always_comb begin
        rdByte = 8'h00;
        if (paddr[1:0] == 2'b00) begin
            case (regIdx)
                IDX_STALL: rdByte = state_r.stallCtl & STALL_WMASK;
                IDX_NAK: rdByte = state_r.nakSeen & NAK_WMASK;
                IDX_DIS_TGL: rdByte = state_r.disTgl & DIS_WMASK;
                IDX_INT_STATUS: rdByte = {4'h0, state_r.intStatus};
                IDX_INT_MASK: rdByte = {4'h0, state_r.intMask};
                default: rdByte = 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // token qualification
    // ---------------------------------------------------------------
    logic tokSetup;
    logic tokInNak;
    logic statusAck;
    logic xferLive;

    assign tokSetup = tokValid && tokKind == TOK_SETUP && tokEp == 2'd0;
    assign tokInNak = tokValid && tokKind == TOK_IN && tokBus.answer == HS_NAK;
    assign statusAck = tokValid && tokStatus && tokEp == 2'd0 &&
        tokKind != TOK_SETUP && tokBus.answer == HS_ACK;

    // a completed transfer only flips the toggle of a live endpoint;
    // endpoint 0 has no disable bit and is always live
    always_comb begin
        case (xferEp)
            2'd1: xferLive = !state_r.disTgl[DIS_EP1];
            2'd2: xferLive = !state_r.disTgl[DIS_EP2];
            2'd3: xferLive = !state_r.disTgl[DIS_EP3];
            default: xferLive = 1'b1;
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        state_nxt.hsValid = 1'b0;
        state_nxt.hsCode = HS_NONE;

        // read data is held until the next read setup cycle
        if (setupRd) begin
            state_nxt.rdData = {24'h000000, rdByte};
        end

        // toggle-clear bits act for one cycle, then drop by themselves;
        // this runs before the bus write so a fresh write is kept
        for (int e = 1; e < 4; e++) begin
            if (state_r.disTgl[TGL_EP1 + e - 1]) begin
                state_nxt.toggle[e] = 1'b0;
                state_nxt.disTgl[TGL_EP1 + e - 1] = 1'b0;
            end
        end

        // completed data transfer flips the toggle of its endpoint
        if (xferOk && xferLive) begin
            state_nxt.toggle[xferEp] = !state_r.toggle[xferEp];
        end

        // software writes, taken at the access edge
        if (accessWr) begin
            case (regIdx)
                IDX_STALL: begin
                    state_nxt.stallCtl = pwdata[7:0] & STALL_WMASK;
                    if ((pwdata[7:0] & STALL_ANY) != 8'h00) begin
                        state_nxt.stallCtl[ACK_STATUS] = 1'b0;
                    end
                end
                IDX_NAK: begin
                    state_nxt.nakSeen = pwdata[7:0] & NAK_WMASK;
                end
                IDX_DIS_TGL: begin
                    state_nxt.disTgl = pwdata[7:0] & DIS_WMASK;
                end
                IDX_INT_STATUS: begin
                    state_nxt.intStatus = state_r.intStatus & ~pwdata[INT_W-1:0];
                end
                IDX_INT_MASK: begin
                    state_nxt.intMask = pwdata[INT_W-1:0];
                end
                default: begin
                    state_nxt.intMask = state_r.intMask;
                end
            endcase
        end

        // hardware events come after the write so they override a same-cycle software write
        if (tokValid) begin
            state_nxt.hsValid = (tokBus.answer != HS_NONE);
            state_nxt.hsCode = tokBus.answer;
        end

        // a setup token restarts the control transfer on endpoint 0
        if (tokSetup) begin
            state_nxt.stallCtl[ACK_STATUS] = 1'b0;
            state_nxt.stallCtl[STL_STATUS] = 1'b0;
            state_nxt.stallCtl[STL_EP0_OUT] = 1'b0;
            state_nxt.stallCtl[STL_EP0_IN] = 1'b0;
            state_nxt.toggle[0] = 1'b1;
            state_nxt.intStatus[INT_SETUP] = 1'b1;
        end

        // status stage acknowledged: the host has seen the ACK
        if (statusAck) begin
            state_nxt.stallCtl[ACK_STATUS] = 1'b0;
            state_nxt.intStatus[INT_STATUS_ACK] = 1'b1;
        end

        // record a NAK returned to an IN token
        if (tokInNak) begin
            case (tokEp)
                2'd0: state_nxt.nakSeen[NAK_EP0] = 1'b1;
                2'd2: state_nxt.nakSeen[NAK_EP2] = 1'b1;
                2'd3: state_nxt.nakSeen[NAK_EP3] = 1'b1;
                default: state_nxt.nakSeen = state_nxt.nakSeen;
            endcase
            state_nxt.intStatus[INT_NAK] = 1'b1;
        end

        // bus reset holds the endpoint controls at their defaults; the
        // interrupt registers survive so software can see the event
        if (busReset) begin
            state_nxt.stallCtl = RST_STALL;
            state_nxt.nakSeen = RST_NAK;
            state_nxt.disTgl = RST_DIS;
            state_nxt.toggle = RST_TOGGLE;
            state_nxt.hsValid = 1'b0;
            state_nxt.hsCode = HS_NONE;
            state_nxt.intStatus[INT_BUS_RESET] = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign prdata = state_r.rdData;
    assign hsValid = state_r.hsValid;
    assign hsCode = state_r.hsCode;
    assign dataToggle = state_r.toggle;
    assign irq = |(state_r.intStatus & state_r.intMask); // level, not a pulse

endmodule : ueh_endpoint_handshake_control
`default_nettype wire

// ==== hw/ueh_handshake_decide.sv ====
// combinational choice of the handshake for one token
`timescale 1ns/100ps
`default_nettype none
module ueh_handshake_decide
    import ueh_pkg::*;
(
    ueh_tok_if.decide tok
);

    // ---------------------------------------------------------------
    // answer selection
    // ---------------------------------------------------------------
    // endpoint stall bits win over every control but the disable bits; a disabled
    // endpoint stays silent so the host times out
    always_comb begin
        tok.answer = HS_NONE;
        case (tok.tokKind)
            TOK_SETUP: begin
                if (tok.tokEp == 2'd0) begin
                    tok.answer = HS_ACK;
                end
            end
            TOK_IN, TOK_OUT: begin
                case (tok.tokEp)
                    2'd0: begin
                        if (tok.stallCtl[tok.tokKind == TOK_IN ? STL_EP0_IN : STL_EP0_OUT]) begin
                            tok.answer = HS_STALL;
                        end else if (tok.tokStatus) begin
                            if (tok.stallCtl[STL_STATUS]) begin
                                tok.answer = HS_STALL;
                            end else if (tok.stallCtl[ACK_STATUS]) begin
                                tok.answer = HS_ACK;
                            end else begin
                                tok.answer = HS_NAK;
                            end
                        end else begin
                            tok.answer = tok.bufReady ? HS_ACK : HS_NAK;
                        end
                    end
                    2'd1: begin
                        if (tok.tokKind == TOK_OUT && !tok.disTgl[DIS_EP1]) begin
                            tok.answer = tok.stallCtl[STL_EP1_OUT] ? HS_STALL :
                                (tok.bufReady ? HS_ACK : HS_NAK);
                        end
                    end
                    2'd2: begin
                        if (tok.tokKind == TOK_IN && !tok.disTgl[DIS_EP2]) begin
                            tok.answer = tok.stallCtl[STL_EP2_IN] ? HS_STALL :
                                (tok.bufReady ? HS_ACK : HS_NAK);
                        end
                    end
                    default: begin
                        if (tok.tokKind == TOK_IN && !tok.disTgl[DIS_EP3]) begin
                            tok.answer = tok.stallCtl[STL_EP3_IN] ? HS_STALL :
                                (tok.bufReady ? HS_ACK : HS_NAK);
                        end
                    end
                endcase
            end
            default: begin
                tok.answer = HS_NONE;
            end
        endcase
    end

endmodule : ueh_handshake_decide
`default_nettype wire

// ==== hw/ueh_pkg.sv ====
// constants and types shared by the endpoint handshake control block
package ueh_pkg;

    // ---------------------------------------------------------------
    // register indexes (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [5:0] IDX_STALL = 6'h08;
    localparam logic [5:0] IDX_NAK = 6'h09;
    localparam logic [5:0] IDX_DIS_TGL = 6'h0a;
    localparam logic [5:0] IDX_INT_STATUS = 6'h0c;
    localparam logic [5:0] IDX_INT_MASK = 6'h0d;

    // ---------------------------------------------------------------
    // endpoint_stall_control fields
    // ---------------------------------------------------------------
    localparam int STL_EP0_IN = 0;
    localparam int STL_EP0_OUT = 1;
    localparam int STL_EP1_OUT = 2;
    localparam int STL_EP2_IN = 3;
    localparam int STL_EP3_IN = 4;
    localparam int STL_STATUS = 5;
    localparam int ACK_STATUS = 6;
    localparam logic [7:0] STALL_WMASK = 8'h7f;
    localparam logic [7:0] STALL_ANY = 8'h3f;
    localparam logic [7:0] RST_STALL = 8'h00;

    // ---------------------------------------------------------------
    // endpoint_nak_events fields
    // ---------------------------------------------------------------
    localparam int NAK_EP0 = 5;
    localparam int NAK_EP2 = 6;
    localparam int NAK_EP3 = 7;
    localparam logic [7:0] NAK_WMASK = 8'he0;
    localparam logic [7:0] RST_NAK = 8'h00;

    // ---------------------------------------------------------------
    // endpoint_disable_toggle_clear fields
    // ---------------------------------------------------------------
    localparam int TGL_EP1 = 2;
    localparam int DIS_EP1 = 5;
    localparam int DIS_EP2 = 6;
    localparam int DIS_EP3 = 7;
    localparam logic [7:0] DIS_WMASK = 8'hfc;
    localparam logic [7:0] RST_DIS = 8'h00;
    localparam logic [3:0] RST_TOGGLE = 4'h0;

    // ---------------------------------------------------------------
    // interrupt status and mask fields
    // ---------------------------------------------------------------
    localparam int INT_W = 4;
    localparam int INT_SETUP = 0;
    localparam int INT_NAK = 1;
    localparam int INT_STATUS_ACK = 2;
    localparam int INT_BUS_RESET = 3;
    localparam logic [3:0] RST_INT = 4'h0;

    // token kinds from the packet engine and handshake answers
    typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT} ueh_tok_t;
    typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} ueh_hs_t;

endpackage : ueh_pkg

// ==== hw/ueh_tok_if.sv ====
// token and control bundle between the register core and the answer logic
`timescale 1ns/100ps
`default_nettype none
interface ueh_tok_if;
    import ueh_pkg::*;
    ueh_tok_t tokKind;
    logic [1:0] tokEp;
    logic tokStatus;
    logic bufReady;
    logic [7:0] stallCtl;
    logic [7:0] disTgl;
    ueh_hs_t answer;

    modport ctrl (output tokKind, tokEp, tokStatus, bufReady, stallCtl, disTgl, input answer);
    modport decide (input tokKind, tokEp, tokStatus, bufReady, stallCtl, disTgl, output answer);
endinterface : ueh_tok_if
`default_nettype wire

// ==== verif/ueh_endpoint_handshake_control_assertions.sv ====
// port-level assertion checker for the endpoint handshake control block
`timescale 1ns/100ps
`default_nettype none
module ueh_endpoint_handshake_control_assertions
    import ueh_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tokValid,
    input wire ueh_tok_t tokKind,
    input wire logic [1:0] tokEp,
    input wire logic tokStatus,
    input wire logic bufReady,
    input wire logic xferOk,
    input wire logic [1:0] xferEp,
    input wire logic busReset,
    input wire logic hsValid,
    input wire ueh_hs_t hsCode,
    input wire logic [3:0] dataToggle,
    input wire logic irq
);
    // ---------------------------------------------------------------
    // properties, all in the one clock domain
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // the setup token on endpoint 0 also owns its toggle, so it is excluded
    logic ep0Setup;
    assign ep0Setup = tokValid && tokKind == TOK_SETUP && tokEp == 2'd0;

    a_ready_no_wait: assert property (psel && penable |-> pready)
        else $error("pready low in an access phase");
    a_reserved_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0 &&
        !(paddr == 8'h20 && prdata[7]) && !(paddr == 8'h24 && prdata[4:0] != 5'h0) &&
        !(paddr == 8'h28 && prdata[1:0] != 2'h0))
        else $error("reserved read bit not zero");
    a_ep0_answers: assert property (tokValid && tokEp == 2'd0 && !busReset |=> hsValid)
        else $error("endpoint 0 token left unanswered");
    a_bus_reset_quiet: assert property (busReset |=> !hsValid && dataToggle == 4'h0)
        else $error("activity or toggle left during bus reset");
    a_answer_has_cause: assert property (hsValid |-> $past(tokValid))
        else $error("handshake without a token");
    a_ep0_toggle_own: assert property (!(xferOk && xferEp == 2'd0) && !ep0Setup &&
        !busReset |=> $stable(dataToggle[0]))
        else $error("endpoint 0 toggle moved without cause");
    a_ep0_toggle_flip: assert property (xferOk && xferEp == 2'd0 && !ep0Setup &&
        !busReset |=> dataToggle[0] != $past(dataToggle[0]))
        else $error("endpoint 0 toggle did not flip");
    a_toggle_clear_ep3: assert property (psel && penable && pwrite && paddr == 8'h28 &&
        pwdata[4] && !busReset |=> ##1 (!dataToggle[3] || $past(xferOk)))
        else $error("endpoint 3 toggle not back to data0");
    a_unmapped_err: assert property (psel && penable && paddr == 8'h2c |-> pslverr)
        else $error("unmapped access without error");
endmodule : ueh_endpoint_handshake_control_assertions

bind ueh_endpoint_handshake_control ueh_endpoint_handshake_control_assertions
    ueh_endpoint_handshake_control_assertions_inst (.*);
`default_nettype wire

// ==== verif/ueh_endpoint_handshake_control_tb_top.sv ====
// self-checking bench for the endpoint handshake control block
`timescale 1ns/100ps
`default_nettype none
module ueh_endpoint_handshake_control_tb_top;
    import ueh_pkg::*;
    localparam logic [7:0] A_STL = {IDX_STALL, 2'b00};
    localparam logic [7:0] A_NAK = {IDX_NAK, 2'b00};
    localparam logic [7:0] A_DIS = {IDX_DIS_TGL, 2'b00};
    localparam logic [7:0] A_IST = {IDX_INT_STATUS, 2'b00};
    localparam logic [7:0] A_IMK = {IDX_INT_MASK, 2'b00};
    logic clock, reset, psel, penable, pwrite, pready, pslverr, lastErr;
    logic tokValid, tokStatus, bufReady, xferOk, busReset, hsValid, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] tokEp, xferEp;
    logic [3:0] dataToggle;
    ueh_tok_t tokKind;
    ueh_hs_t hsCode, hs;
    int miscompares = 0;
    int comparisons = 0;

    ueh_endpoint_handshake_control ueh_endpoint_handshake_control_inst (.*);
    ueh_host_model ueh_host_model_inst (.*);

    // ---------------------------------------------------------------
    // checking and bus tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // apb transfer; waits on pready with no assumed count, only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), rd, {24'h0, exp});
    endtask : rchk

    task automatic tchk(input ueh_tok_t k, input logic [1:0] ep, input logic st,
                        input logic rdy, input ueh_hs_t exp);
        ueh_host_model_inst.token(k, ep, st, rdy, hs);
        chk($sformatf("answer %s ep%0d", k.name(), ep), hs, exp);
    endtask : tchk

    // lets registered side effects of the previous access land
    task automatic settle;
        repeat (2) @(posedge clock);
        #1;
    endtask : settle

    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    // ---------------------------------------------------------------
    // clock, watchdog and scenarios
    // ---------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // whole sequence needs well under 2000 cycles
    initial begin
        #50000;
        miscompares++;
        give_verdict();
    end

    initial begin
        {reset, psel, penable, pwrite} = 4'h8;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        rchk(A_STL, 8'h00);
        rchk(A_NAK, 8'h00);
        rchk(A_DIS, 8'h00);
        apb(1'b0, 8'h2c, 32'h0);
        chk("unmapped error", lastErr, 1'b1);
        // status stage: nak until acknowledged, then ack once
        tchk(TOK_SETUP, 2'd0, 1'b0, 1'b0, HS_ACK);
        tchk(TOK_OUT, 2'd0, 1'b1, 1'b1, HS_NAK);
        apb(1'b1, A_STL, 32'h40);
        tchk(TOK_OUT, 2'd0, 1'b1, 1'b0, HS_ACK);
        rchk(A_STL, 8'h00);
        // setup seen and status stage acknowledged both flagged
        rchk(A_IST, 8'h05);
        apb(1'b1, A_STL, 32'h40);
        apb(1'b1, A_STL, 32'h00);
        rchk(A_STL, 8'h00);
        apb(1'b1, A_STL, 32'h40);
        apb(1'b1, A_STL, 32'h48);
        rchk(A_STL, 8'h08);
        // every stall bit overrides an armed endpoint
        apb(1'b1, A_STL, 32'hff);
        rchk(A_STL, 8'h3f);
        tchk(TOK_IN, 2'd0, 1'b0, 1'b1, HS_STALL);
        tchk(TOK_OUT, 2'd0, 1'b0, 1'b1, HS_STALL);
        tchk(TOK_OUT, 2'd1, 1'b0, 1'b1, HS_STALL);
        tchk(TOK_IN, 2'd2, 1'b0, 1'b1, HS_STALL);
        tchk(TOK_IN, 2'd3, 1'b0, 1'b1, HS_STALL);
        apb(1'b1, A_STL, 32'h20);
        tchk(TOK_OUT, 2'd0, 1'b1, 1'b0, HS_STALL);
        rchk(A_STL, 8'h20);
        apb(1'b1, A_STL, 32'h3f);
        tchk(TOK_SETUP, 2'd0, 1'b0, 1'b0, HS_ACK);
        rchk(A_STL, 8'h1c);
        // nak events, sticky flags and the masked interrupt
        apb(1'b1, A_STL, 32'h00);
        apb(1'b1, A_IST, 32'hf);
        tchk(TOK_IN, 2'd2, 1'b0, 1'b0, HS_NAK);
        tchk(TOK_IN, 2'd3, 1'b0, 1'b0, HS_NAK);
        tchk(TOK_IN, 2'd0, 1'b0, 1'b0, HS_NAK);
        rchk(A_NAK, 8'he0);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, A_IMK, 32'h2);
        settle();
        chk("irq raised", irq, 1'b1);
        apb(1'b1, A_IST, 32'hf);
        settle();
        chk("irq cleared", irq, 1'b0);
        rchk(A_NAK, 8'he0);
        apb(1'b1, A_NAK, 32'hff);
        rchk(A_NAK, 8'he0);
        apb(1'b1, A_NAK, 32'h00);
        rchk(A_NAK, 8'h00);
        // disabled endpoints are silent and keep their state
        apb(1'b1, A_DIS, 32'he0);
        rchk(A_DIS, 8'he0);
        tchk(TOK_OUT, 2'd1, 1'b0, 1'b1, HS_NONE);
        tchk(TOK_IN, 2'd2, 1'b0, 1'b0, HS_NONE);
        tchk(TOK_IN, 2'd3, 1'b0, 1'b1, HS_NONE);
        ueh_host_model_inst.xfer(2'd2);
        #1 chk("toggle ep2", dataToggle[2], 1'b0);
        rchk(A_NAK, 8'h00);
        tchk(TOK_IN, 2'd0, 1'b0, 1'b1, HS_ACK);
        apb(1'b1, A_DIS, 32'h00);
        tchk(TOK_IN, 2'd3, 1'b0, 1'b1, HS_ACK);
        // bus reset returns the endpoint registers and toggles to defaults
        apb(1'b1, A_STL, 32'hff);
        apb(1'b1, A_NAK, 32'hff);
        apb(1'b1, A_DIS, 32'hff);
        ueh_host_model_inst.bus_reset(3);
        #1 chk("toggles after bus reset", dataToggle, 4'h0);
        rchk(A_STL, 8'h00);
        rchk(A_NAK, 8'h00);
        rchk(A_DIS, 8'h00);
        // only the bus reset event is pending; mask survives the bus reset
        rchk(A_IST, 8'h08);
        rchk(A_IMK, 8'h02);
        // toggle clear forces data0 and self-clears, endpoint 0 untouched
        for (int e = 0; e < 4; e++) ueh_host_model_inst.xfer(e[1:0]);
        #1 chk("toggles flipped", dataToggle, 4'hf);
        apb(1'b1, A_DIS, 32'h1f);
        settle();
        chk("toggles cleared", dataToggle, 4'h1);
        rchk(A_DIS, 8'h00);
        give_verdict();
    end
endmodule : ueh_endpoint_handshake_control_tb_top
`default_nettype wire

// ==== verif/ueh_host_model.sv ====
// host side model: issues tokens, transfer results and bus resets
`timescale 1ns/100ps
`default_nettype none
module ueh_host_model
    import ueh_pkg::*;
(
    input wire logic clock,
    output logic tokValid,
    output ueh_tok_t tokKind,
    output logic [1:0] tokEp,
    output logic tokStatus,
    output logic bufReady,
    output logic xferOk,
    output logic [1:0] xferEp,
    output logic busReset,
    input wire logic hsValid,
    input wire ueh_hs_t hsCode
);
    // ---------------------------------------------------------------
    // idle bus at time zero
    // ---------------------------------------------------------------
    initial begin
        {tokValid, tokStatus, bufReady, xferOk, busReset} = 5'h0;
        tokKind = TOK_IN;
        tokEp = 2'd0;
        xferEp = 2'd0;
    end

    // one-cycle token; endpoint and buffer-ready are inverted afterwards so stale values never help
    task automatic token(input ueh_tok_t k, input logic [1:0] ep, input logic st,
                         input logic rdy, output ueh_hs_t hs);
        @(posedge clock);
        tokValid <= 1'b1;
        tokKind <= k;
        tokEp <= ep;
        tokStatus <= st;
        bufReady <= rdy;
        @(posedge clock);
        tokValid <= 1'b0;
        tokEp <= ~ep;
        bufReady <= ~rdy;
        #1 hs = (hsValid === 1'b1) ? hsCode : HS_NONE;
    endtask : token

    // one completed data transfer on an endpoint
    task automatic xfer(input logic [1:0] ep);
        @(posedge clock);
        xferOk <= 1'b1;
        xferEp <= ep;
        @(posedge clock);
        xferOk <= 1'b0;
        xferEp <= ~ep;
    endtask : xfer

    // bus reset held for n cycles
    task automatic bus_reset(input int n);
        @(posedge clock);
        busReset <= 1'b1;
        repeat (n) @(posedge clock);
        busReset <= 1'b0;
    endtask : bus_reset
endmodule : ueh_host_model
`default_nettype wire
